/* File: design/sac_ctrl.sv */
// Conversion control and result port of a 16-bit successive-approximation converter.
// Assumes pins arrive asynchronously; the comparator is on-chip and on ref_clk.
`include "sac_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic convert_start_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic sclk_in,
	input wire logic serial_parallel_select,
	input wire logic clock_source_select,
	input wire logic power_down,
	input wire logic low_power_select,
	input wire logic fast_select,
	input wire logic comparator_high,
	output logic [15:0] data_out,
	output logic [15:0] data_oe,
	output logic busy,
	output logic sample_hold,
	output logic [15:0] dac_code,
	output logic low_consumption
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic slave_mode(input logic ser, input logic ext);
		slave_mode = ser && ext;
	endfunction : slave_mode

	localparam logic [7:0] ACQ_CYC = 8'(`SAC_ACQ_CYC);
	localparam logic [3:0] CONV_DIV = 4'(`SAC_CONV_DIV - 1);
	localparam logic [3:0] SCLK_DIV = 4'(`SAC_SCLK_DIV - 1);

	// Pin order: start, cs, rd, sclk, ser, ext, pd, lowpower, fast
	wire [8:0] pin_raw = {convert_start_n, cs_n, rd_n, sclk_in, serial_parallel_select,
		clock_source_select, power_down, low_power_select, fast_select};
	logic [8:0] meta_r;
	logic [8:0] sync_r;
	logic start_prev_r;
	logic sclk_prev_r;

	always_ff @(posedge ref_clk) begin
		meta_r <= pin_raw;
		sync_r <= meta_r;
		start_prev_r <= sync_r[8];
		sclk_prev_r <= sync_r[5];
	end

	wire start_s = sync_r[8];
	wire cs_s = sync_r[7];
	wire rd_s = sync_r[6];
	wire ser_s = sync_r[4];
	wire ext_s = sync_r[3];
	wire pd_s = sync_r[2];
	wire lowpwr_s = sync_r[1] && !sync_r[0];
	wire start_fall = start_prev_r && !start_s;
	wire sclk_rise = !sclk_prev_r && sync_r[5];
	wire read_en = !cs_s && !rd_s;
	wire slave = slave_mode(ser_s, ext_s);

	////////////////////////////////////////////////////////////////////////
	// Conversion and serial clock dividers
	logic [3:0] conv_div_r;
	logic [3:0] sclk_div_r;
	logic int_sclk_r;
	wire conv_tick = (conv_div_r == CONV_DIV);
	wire int_tick = (sclk_div_r == SCLK_DIV);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			conv_div_r <= '0;
			sclk_div_r <= '0;
			int_sclk_r <= 1'b0;
		end else begin
			conv_div_r <= conv_tick ? 4'h0 : conv_div_r + 4'h1;
			sclk_div_r <= int_tick ? 4'h0 : sclk_div_r + 4'h1;
			if (int_tick) begin
				int_sclk_r <= !int_sclk_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	sac_pkg::sac_state_e state_r, state_nxt;
	logic [3:0] step_r;
	logic [15:0] code_r;
	logic [7:0] acq_cnt_r;
	logic busy_r;
	logic hold_r;
	logic lowcons_r;

	sac_fifo_if #(.WIDTH(`SAC_RES_BITS)) rq ();
	sac_fifo #(.WIDTH(`SAC_RES_BITS), .DEPTH(`SAC_FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.q(rq.fifo)
	);

	// Normal mode when both selects low: no interval limit
	wire start_go = (state_r == sac_pkg::ST_IDLE) && start_fall && !pd_s;
	wire acq_go = (state_r == sac_pkg::ST_ACQ) && (acq_cnt_r == 8'h00) && !start_s && !pd_s;
	wire conv_done = (state_r == sac_pkg::ST_CONV) && conv_tick && (step_r == 4'h0);
	wire [15:0] code_kept = comparator_high ? code_r : (code_r & ~(16'h0001 << step_r));
	wire [15:0] code_next = (step_r == 4'h0) ? code_kept : (code_kept | (16'h0001 << (step_r - 4'h1)));
	wire load = rq.out_valid && rq.out_ready;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sac_pkg::ST_IDLE: state_nxt = start_go ? sac_pkg::ST_CONV : state_r;
			sac_pkg::ST_CONV: state_nxt = conv_done ? sac_pkg::ST_PUSH : state_r;
			sac_pkg::ST_PUSH: state_nxt = rq.in_ready ? sac_pkg::ST_LOAD : state_r;
			sac_pkg::ST_LOAD: state_nxt = !load ? state_r : (lowpwr_s ? sac_pkg::ST_ACQ : sac_pkg::ST_IDLE);
			sac_pkg::ST_ACQ: begin
				if (acq_cnt_r == 8'h00) begin
					state_nxt = acq_go ? sac_pkg::ST_CONV : sac_pkg::ST_IDLE;
				end
			end
			default: state_nxt = sac_pkg::ST_IDLE;
		endcase
	end

	wire busy_nxt = (state_nxt == sac_pkg::ST_CONV) || (state_nxt == sac_pkg::ST_PUSH)
		|| (state_nxt == sac_pkg::ST_LOAD);
	wire conv_enter = (state_r != sac_pkg::ST_CONV) && (state_nxt == sac_pkg::ST_CONV);

	assign rq.in_valid = (state_r == sac_pkg::ST_PUSH);
	assign rq.in_data = code_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= sac_pkg::ST_IDLE;
			busy_r <= 1'b0;
			hold_r <= 1'b0;
			lowcons_r <= 1'b0;
			step_r <= 4'hF;
			code_r <= 16'h0000;
			acq_cnt_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			busy_r <= busy_nxt;
			hold_r <= (state_nxt == sac_pkg::ST_CONV);
			lowcons_r <= pd_s && (state_nxt == sac_pkg::ST_IDLE);
			if (conv_enter) begin
				step_r <= 4'hF;
				code_r <= `SAC_SAR_INIT;
			end else if (state_r == sac_pkg::ST_CONV && conv_tick) begin
				step_r <= step_r - 4'h1;
				code_r <= code_next;
			end
			if (state_nxt == sac_pkg::ST_ACQ && state_r != sac_pkg::ST_ACQ) begin
				acq_cnt_r <= ACQ_CYC - 8'h01;
			end else if (state_r == sac_pkg::ST_ACQ && acq_cnt_r != 8'h00) begin
				acq_cnt_r <= acq_cnt_r - 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output shift register and read port
	logic [15:0] result_r;
	logic [15:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic rderr_r;
	wire reading = (bit_cnt_r != 4'h0);
	wire rderr_nxt = slave && reading && conv_done;
	// A started serial read blocks the FIFO unless a slave-mode conversion ends mid-read, which aborts the read
	assign rq.out_ready = !reading || rderr_nxt;
	wire sclk_ok = ext_s ? (sclk_rise && !cs_s) : int_tick;
	wire shift_tick = ser_s && read_en && sclk_ok;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result_r <= 16'h0000;
			shift_r <= 16'h0000;
			bit_cnt_r <= 4'h0;
			rderr_r <= 1'b0;
		end else begin
			rderr_r <= rderr_nxt;
			if (rderr_nxt) begin
				bit_cnt_r <= 4'h0;
			end else if (load) begin
				result_r <= rq.out_data;
				shift_r <= rq.out_data;
				bit_cnt_r <= 4'h0;
			end else if (shift_tick) begin
				shift_r <= {shift_r[14:0], 1'b0};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
		end
	end

	logic [15:0] out_nxt;
	logic [15:0] oe_nxt;
	always_comb begin
		out_nxt = result_r;
		oe_nxt = {4'hF, {12{read_en}}};
		if (ser_s) begin
			out_nxt[11:0] = 12'h000;
			oe_nxt[11:0] = 12'h000;
			out_nxt[`SAC_BIT_SDATA] = shift_r[15];
			oe_nxt[`SAC_BIT_SDATA] = read_en;
			out_nxt[`SAC_BIT_SCLK] = int_sclk_r;
			oe_nxt[`SAC_BIT_SCLK] = read_en && !ext_s;
			out_nxt[`SAC_BIT_SYNC] = reading;
			oe_nxt[`SAC_BIT_SYNC] = read_en && !ext_s;
			out_nxt[`SAC_BIT_ERRFLAG] = slave && rderr_r;
			oe_nxt[`SAC_BIT_ERRFLAG] = slave;
		end
	end

	logic [15:0] data_out_r;
	logic [15:0] data_oe_r;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			data_out_r <= 16'h0000;
			data_oe_r <= 16'hF000;
		end else begin
			data_out_r <= out_nxt;
			data_oe_r <= oe_nxt;
		end
	end

	assign data_out = data_out_r;
	assign data_oe = data_oe_r;
	assign busy = busy_r;
	assign sample_hold = hold_r;
	assign dac_code = code_r;
	assign low_consumption = lowcons_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_par_bit11;
		(!ser_s && read_en) |=> (data_out_r[11] == $past(result_r[11]) && data_oe_r[11]);
	endproperty
	a_par_bit11: assert property (p_par_bit11) else $error("bit 11 not result in parallel");
	property p_flag_pin;
		(slave && rderr_r) |=> (data_out_r[`SAC_BIT_ERRFLAG] && data_oe_r[`SAC_BIT_ERRFLAG]);
	endproperty
	a_flag_pin: assert property (p_flag_pin) else $error("error flag not on shared pin");
	property p_rderr_pulse;
		(slave && reading && conv_done) |=> (rderr_r ##1 (!rderr_r && !reading));
	endproperty
	a_rderr_pulse: assert property (p_rderr_pulse) else $error("late read not flagged");
	property p_upper_oe;
		data_oe_r[15:12] == 4'hF;
	endproperty
	a_upper_oe: assert property (p_upper_oe) else $error("upper bits not driven");
	property p_busy_span;
		start_go |=> (busy_r && hold_r) [*8];
	endproperty
	a_busy_span: assert property (p_busy_span) else $error("busy not held in conversion");
	property p_oe_gate;
		(!read_en && !ser_s) |=> (data_oe_r[11:0] == 12'h000);
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("output enabled without read");
	property p_sclk_gate;
		(ser_s && ext_s && cs_s && !rderr_nxt && !load) |=> $stable(bit_cnt_r);
	endproperty
	a_sclk_gate: assert property (p_sclk_gate) else $error("serial clock not gated");
	property p_reset_idle;
		$fell(rst) |-> (state_r == sac_pkg::ST_IDLE && !busy_r);
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
	property p_pd_block;
		(state_r == sac_pkg::ST_IDLE && pd_s) |=> (state_r == sac_pkg::ST_IDLE && lowcons_r);
	endproperty
	a_pd_block: assert property (p_pd_block) else $error("start taken in power-down");
	property p_lp_restart;
		(state_r == sac_pkg::ST_ACQ && acq_cnt_r == 8'h00 && !start_s && !pd_s) |=> busy_r && hold_r;
	endproperty
	a_lp_restart: assert property (p_lp_restart) else $error("no low-power restart");
endmodule : sac_ctrl
`default_nettype wire

/* File: design/sac_params.svh */
// Timing counts and field positions for the converter control port.
// Assumes the 200 MHz core clock; included by the control file only.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

`define SAC_CLK_MHZ 200
`define SAC_ACQ_NS 100
`define SAC_ACQ_CYC ((`SAC_ACQ_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_CONV_DIV 4
`define SAC_SCLK_DIV 8
`define SAC_RES_BITS 16
`define SAC_FIFO_DEPTH 16
`define SAC_BIT_ERRFLAG 11
`define SAC_BIT_SDATA 8
`define SAC_BIT_SCLK 9
`define SAC_BIT_SYNC 10
`define SAC_UPPER_LO 12
`define SAC_SAR_INIT 16'h8000

`endif

/* File: design/sac_pkg.sv */
// Types shared by the converter control port.
// Assumes nothing beyond a SystemVerilog compiler.
package sac_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_CONV, ST_PUSH, ST_LOAD, ST_ACQ} sac_state_e;
	typedef logic [15:0] sac_word_t;
endpackage : sac_pkg

/* File: design/sac_fifo_if.sv */
// Stream carrier between the control logic and the result FIFO.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface sac_fifo_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] in_data;
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] out_data;
	logic out_valid;
	logic out_ready;
	modport src (output in_data, output in_valid, input in_ready,
		input out_data, input out_valid, output out_ready);
	modport fifo (input in_data, input in_valid, output in_ready,
		output out_data, output out_valid, input out_ready);
endinterface : sac_fifo_if
`default_nettype wire

/* File: design/sac_fifo.sv */
// Result FIFO between the converter and the output shift register.
// Assumes a synchronous active-high reset on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module sac_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	sac_fifo_if.fifo q
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	wire empty = (wr_ptr_r == rd_ptr_r);
	wire push = q.in_valid && !full;
	wire pop = q.out_valid && q.out_ready;

	assign q.in_ready = !full;
	assign q.out_valid = !empty;
	assign q.out_data = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= q.in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
			rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
		end
	end
endmodule : sac_fifo
`default_nettype wire

/* File: test/sac_host_model.sv */
// Host controller model: chip select, read strobe and serial clock.
// Assumes the converter samples these pins through its own synchronisers.
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
	input wire logic ref_clk,
	input wire logic busy,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	output logic cs_n,
	output logic rd_n,
	output logic sclk_in
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		sclk_in = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic par_read(output logic [15:0] v, output logic [15:0] oe);
		while (busy !== 1'b0) cyc(1); // Read only after data ready
		cs_n = 1'b0; // Both strobes low for the whole read
		rd_n = 1'b0;
		cyc(4);
		v = data_out;
		oe = data_oe;
		cs_n = 1'b1;
		rd_n = 1'b1;
		cyc(4);
	endtask : par_read
	// Serial clock stands still outside frames; sel low toggles sclk with cs_n high, which shifts nothing
	task automatic ser_read(input int n, input logic sel, output logic [15:0] v);
		cs_n = !sel;
		rd_n = 1'b0;
		cyc(4);
		v = 16'h0000;
		for (int i = 0; i < n; i++) begin
			v = {v[14:0], data_out[8]};
			sclk_in = 1'b1;
			cyc(4);
			sclk_in = 1'b0;
			cyc(4);
		end
		cs_n = 1'b1;
		rd_n = 1'b1;
		cyc(4);
	endtask : ser_read
endmodule : sac_host_model
`default_nettype wire

/* File: test/sar_adc_conversion_control_port_tb.sv */
// Self-checking bench for the converter control port.
// Assumes the host model is compiled first; comparator is modelled here.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_port_tb;
	logic ref_clk, rst, convert_start_n, cs_n, rd_n, sclk_in, serial_parallel_select;
	logic clock_source_select, power_down, low_power_select, fast_select, comparator_high;
	logic busy, sample_hold, low_consumption;
	logic [15:0] data_out, data_oe, dac_code;
	logic [31:0] ana = 32'h1718d69e;
	logic [15:0] exp_q[$];
	int err_total = 0, check_count = 0, cycles = 0, flag_cnt = 0;
	// Ideal comparator: keep the trial bit while the code is not above the input
	assign comparator_high = (dac_code <= ana[15:0]);
	sac_ctrl DUT (.ref_clk, .rst, .convert_start_n, .cs_n, .rd_n, .sclk_in, .serial_parallel_select,
		.clock_source_select, .power_down, .low_power_select, .fast_select, .comparator_high,
		.data_out, .data_oe, .busy, .sample_hold, .dac_code, .low_consumption);
	sac_host_model host (.ref_clk, .busy, .data_out, .data_oe, .cs_n, .rd_n, .sclk_in);
	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h saw %h", nm, e, s);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic wait_busy(input logic lvl, input int lim);
		for (int k = 0; k < lim && busy !== lvl; k++) cyc(1);
	endtask : wait_busy
	task automatic start_conv;
		ana = lfsr(ana);
		exp_q.push_back(ana[15:0]);
		convert_start_n = 1'b0;
		cyc(5);
		convert_start_n = 1'b1;
		wait_busy(1'b1, 10);
		check("busy_up", 16'({busy, sample_hold}), 16'h0003);
	endtask : start_conv
	task automatic end_conv;
		wait_busy(1'b0, 100);
		check("busy_dn", 16'(busy), 16'h0000);
	endtask : end_conv
	////////////////////////////////////////////////////////////////////////
	// Hang guard; the whole run needs under two thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			give_verdict();
		end
	end
	always @(posedge ref_clk)
		if (serial_parallel_select && data_out[11] === 1'b1) flag_cnt++;
	initial begin
		logic [15:0] v, oe;
		{convert_start_n, rst} = 2'b11;
		{serial_parallel_select, clock_source_select, power_down, low_power_select, fast_select} = 5'h00;
		cyc(3);
		rst = 1'b0;
		check("rst_state", {busy, data_oe[14:0]}, 16'h7000);
		cyc(4);
		repeat (4) begin
			start_conv();
			end_conv();
			host.par_read(v, oe);
			check("par_data", v, exp_q.pop_front());
			check("par_oe", oe, 16'hFFFF);
			check("idle_oe", data_oe, 16'hF000);
		end
		$display("parallel test done");
		{serial_parallel_select, clock_source_select} = 2'b11;
		cyc(4);
		flag_cnt = 0;
		start_conv();
		end_conv();
		host.ser_read(5, 1'b0, v);
		host.ser_read(16, 1'b1, v);
		check("ser_data", v, exp_q.pop_front());
		check("ser_oe", data_oe, 16'hF800);
		start_conv();
		end_conv();
		host.ser_read(3, 1'b1, v);
		check("no_flag", 16'(flag_cnt), 16'h0000);
		start_conv();
		end_conv();
		cyc(4);
		check("err_flag", 16'(flag_cnt), 16'h0001);
		void'(exp_q.pop_front());
		host.ser_read(16, 1'b1, v);
		check("ser_new", v, exp_q.pop_front());
		$display("serial test done");
		start_conv();
		power_down = 1'b1;
		end_conv();
		convert_start_n = 1'b0;
		cyc(5);
		convert_start_n = 1'b1;
		cyc(20);
		check("pd_idle", 16'({busy, low_consumption}), 16'h0001);
		power_down = 1'b0;
		low_power_select = 1'b1;
		cyc(4);
		convert_start_n = 1'b0;
		wait_busy(1'b1, 10);
		wait_busy(1'b0, 100);
		wait_busy(1'b1, 60);
		check("lp_restart", 16'(busy), 16'h0001);
		convert_start_n = 1'b1;
		end_conv();
		low_power_select = 1'b0;
		cyc(24); // Starts are ignored until the acquisition interval runs out
		$display("power test done");
		clock_source_select = 1'b0;
		cyc(4);
		host.par_read(v, oe);
		check("int_oe", oe, 16'hF700);
		$display("master test done");
		start_conv();
		cyc(10);
		rst = 1'b1;
		cyc(1);
		rst = 1'b0;
		check("abort", {busy, data_oe[14:0]}, 16'h7000);
		$display("reset test done");
		give_verdict();
	end
endmodule : sar_adc_conversion_control_port_tb
`default_nettype wire
